// *** rtl/msp_pkg.sv ***
package msp_pkg;

	// Reference power modes.
	localparam logic [1:0] REF_MODE_PER_TEMP = 2'h0;
	localparam logic [1:0] REF_MODE_PER_SCAN = 2'h1;
	localparam logic [1:0] REF_MODE_ALWAYS   = 2'h2;

	// Wait below this keeps the reference on, in microseconds.
	localparam int         REF_HOLD_WAIT_US  = 80;
	localparam int         WAIT_W            = 16;

	// Shift register widths.
	localparam int         SHIFT_W           = 8;
	localparam int         CNT_W             = 3;
	localparam logic [CNT_W-1:0] CNT_LAST    = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 3'h0;

	// Channel counts.
	localparam int         NUM_CH            = 8;
	localparam int         NUM_PAIR          = 4;

	// Synchronised serial pins travel together.
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
	} msp_pins_t;

	// Alarm pin drive configuration.
	typedef struct packed {
		logic open_drain;
		logic active_high;
	} msp_alarm_cfg_t;

	typedef enum logic [0:0] {
		MSP_IDLE,
		MSP_XFER
	} msp_state_t;

endpackage : msp_pkg

// *** rtl/msp_serial_port.sv ***
module msp_serial_port
	import msp_pkg::*;
(
	// Clock and reset.
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Serial pins from the host.
	input  wire logic                  cs_n,
	input  wire logic                  sclk,
	input  wire logic                  sdi,
	// Serial output pin.
	output logic                       sdo_o,
	output logic                       sdo_oe,
	// Parallel data to and from the core.
	input  wire logic [SHIFT_W-1:0]    tx_word,
	output logic [SHIFT_W-1:0]         rx_word,
	output logic                       rx_valid,
	output logic                       xfer_start,
	// Alarm pin.
	input  wire logic                  alarm_event,
	input  wire msp_alarm_cfg_t        alarm_cfg,
	output logic                       alarm_o,
	output logic                       alarm_oe,
	// Reference power control.
	input  wire logic [1:0]            ref_mode,
	input  wire logic [WAIT_W-1:0]     scan_wait_us,
	input  wire logic                  temp_conv_busy,
	input  wire logic                  scan_busy,
	output logic                       ref_power_on,
	// Differential channel routing.
	input  wire logic                  diff_mode,
	input  wire logic [CNT_W-1:0]      chan_sel,
	output logic [CNT_W-1:0]           mux_pos,
	output logic [CNT_W-1:0]           mux_neg,
	output logic                       mux_neg_gnd
);

	// The serial pins belong to no clock of ours. The host may move them at any
	// moment, so every pin first passes two flip-flops before logic looks at it.
	// This costs about three system clocks of latency on each edge. The host's
	// minimum high and low times must therefore span several system clocks.
	// A serial clock that is too fast for that would lose edges, not corrupt them.
	// Chip select resets to high so that leaving reset never looks like a select.
	// The serial clock resets low; in mode 3 the first sampled high level would
	// look like a rise, but chip select is still high then and the rise is ignored.
	// The data line resets low; its value is only read at a detected rise.
	//
	// Two-stage synchronisers; the first stage feeds only the second.
	msp_pins_t pin_s1_r, pin_s2_r, pin_d_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
			pin_s2_r <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
			pin_d_r  <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
		end else begin
			pin_s1_r <= '{cs_n: cs_n, sclk: sclk, sdi: sdi};
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end

	// A third stage holds the previous synchronised level for edge detection.
	// Comparing the second and third stages keeps the detector off the first
	// stage, which may still be settling from a metastable sample.
	// Each detected edge lasts exactly one system clock.
	//
	// Edge detection on the synchronised copies.
	logic sclk_rise, sclk_fall, cs_fall;
	assign sclk_rise = pin_s2_r.sclk & ~pin_d_r.sclk;
	assign sclk_fall = ~pin_s2_r.sclk & pin_d_r.sclk;
	assign cs_fall   = ~pin_s2_r.cs_n & pin_d_r.cs_n;

	// The port has only two states. Idle waits for a select; the transfer state
	// counts bits modulo eight, so bytes may follow each other without a gap.
	// A partial byte is dropped when chip select rises, since the counter and
	// state return to idle there and no valid pulse is given for it.
	// The sent flag blocks the first fall in mode 3, which comes before any rise.
	//
	// Serial port state.
	msp_state_t           state_r, state_nxt;
	logic [SHIFT_W-1:0]   rx_sh_r, rx_sh_nxt;
	logic [SHIFT_W-1:0]   tx_sh_r, tx_sh_nxt;
	logic [CNT_W-1:0]     bit_cnt_r, bit_cnt_nxt;
	logic [SHIFT_W-1:0]   rx_word_r, rx_word_nxt;
	logic                 rx_valid_r, rx_valid_nxt;
	logic                 start_r, start_nxt;
	logic                 sdo_r, sdo_nxt;
	logic                 sdo_oe_r, sdo_oe_nxt;
	logic                 sent_r, sent_nxt;

	// The shift engine. With the mode-0 and mode-3 clocking that the host keeps,
	// the first bit must be on the pin before the first rise, so it is loaded at
	// the chip select fall and later bits move on falls.
	always_comb begin
		state_nxt    = state_r;
		rx_sh_nxt    = rx_sh_r;
		tx_sh_nxt    = tx_sh_r;
		bit_cnt_nxt  = bit_cnt_r;
		rx_word_nxt  = rx_word_r;
		rx_valid_nxt = 1'b0;
		start_nxt    = 1'b0;
		sdo_nxt      = sdo_r;
		sdo_oe_nxt   = sdo_oe_r;
		sent_nxt     = sent_r;
		if (pin_s2_r.cs_n) begin
			// Chip select high resets the state, bit count, output bit and sent flag and releases the pin.
			state_nxt   = MSP_IDLE;
			bit_cnt_nxt = CNT_ZERO;
			sdo_oe_nxt  = 1'b0;
			sdo_nxt     = 1'b0;
			sent_nxt    = 1'b0;
		end else begin
			case (state_r)
				MSP_IDLE: begin
					if (cs_fall) begin
						// A falling chip select opens a new transfer.
						state_nxt   = MSP_XFER;
						start_nxt   = 1'b1;
						bit_cnt_nxt = CNT_ZERO;
						tx_sh_nxt   = {tx_word[SHIFT_W-2:0], 1'b0};
						sdo_nxt     = tx_word[SHIFT_W-1];
						sdo_oe_nxt  = 1'b1;
						sent_nxt    = 1'b0;
					end
				end
				MSP_XFER: begin
					if (sclk_rise) begin
						// Capture the input bit on the rising clock edge.
						rx_sh_nxt   = {rx_sh_r[SHIFT_W-2:0], pin_s2_r.sdi};
						bit_cnt_nxt = bit_cnt_r + 3'h1;
						sent_nxt    = 1'b1;
						if (bit_cnt_r == CNT_LAST) begin
							rx_word_nxt  = {rx_sh_r[SHIFT_W-2:0], pin_s2_r.sdi};
							rx_valid_nxt = 1'b1;
						end
					end else if (sclk_fall && sent_r) begin
						// Output moves only on falling clock edges.
						if (bit_cnt_r == CNT_ZERO) begin
							sdo_nxt   = tx_word[SHIFT_W-1];
							tx_sh_nxt = {tx_word[SHIFT_W-2:0], 1'b0};
						end else begin
							sdo_nxt   = tx_sh_r[SHIFT_W-1];
							tx_sh_nxt = {tx_sh_r[SHIFT_W-2:0], 1'b0};
						end
					end
				end
				default: state_nxt = MSP_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= MSP_IDLE;
			rx_sh_r    <= '0;
			tx_sh_r    <= '0;
			bit_cnt_r  <= CNT_ZERO;
			rx_word_r  <= '0;
			rx_valid_r <= 1'b0;
			start_r    <= 1'b0;
			sdo_r      <= 1'b0;
			sdo_oe_r   <= 1'b0;
			sent_r     <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			rx_sh_r    <= rx_sh_nxt;
			tx_sh_r    <= tx_sh_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			rx_word_r  <= rx_word_nxt;
			rx_valid_r <= rx_valid_nxt;
			start_r    <= start_nxt;
			sdo_r      <= sdo_nxt;
			sdo_oe_r   <= sdo_oe_nxt;
			sent_r     <= sent_nxt;
		end
	end

	// All port outputs come straight from their registers.
	// The output enable drops while chip select is high, so the pin floats then.
	assign sdo_o      = sdo_r;
	assign sdo_oe     = sdo_oe_r;
	assign rx_word    = rx_word_r;
	assign rx_valid   = rx_valid_r;
	assign xfer_start = start_r;

	// The alarm condition arrives from logic on this clock, so it needs no
	// synchroniser. The pin follows it one clock later in every configuration.
	// Reset leaves the pin undriven until the first clock after release.
	//
	// Alarm pin drive. Open-drain only pulls to the active level when that is low;
	// an active-high open-drain alarm relies on an external pull-up instead.
	logic alarm_r, alarm_nxt, alarm_oe_r, alarm_oe_nxt;

	always_comb begin
		alarm_nxt    = alarm_event ~^ alarm_cfg.active_high;
		alarm_oe_nxt = 1'b1;
		if (alarm_cfg.open_drain) begin
			// Drive only while the pin should sit low.
			alarm_nxt    = 1'b0;
			alarm_oe_nxt = ~(alarm_event ~^ alarm_cfg.active_high);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_r    <= 1'b0;
			alarm_oe_r <= 1'b0;
		end else begin
			alarm_r    <= alarm_nxt;
			alarm_oe_r <= alarm_oe_nxt;
		end
	end

	assign alarm_o  = alarm_r;
	assign alarm_oe = alarm_oe_r;

	// The reference enable is a plain level computed each clock from the mode.
	// Per-measurement mode follows the temperature conversion busy level.
	// Per-scan mode follows the scan busy level, but a short wait between scans
	// would cycle the reference faster than it can settle, so it stays on then.
	// The threshold compare uses whole microseconds; the core supplies the wait.
	// The reserved mode encoding is treated as always on, which is the safe
	// choice: a powered reference costs current, an unpowered one costs results.
	// The enable is held low during reset so that power-up starts quiet.
	//
	// Reference power policy.
	logic ref_r, ref_nxt;
	logic short_wait;
	assign short_wait = scan_wait_us < WAIT_W'(REF_HOLD_WAIT_US);

	always_comb begin
		case (ref_mode)
			REF_MODE_PER_TEMP: ref_nxt = temp_conv_busy;
			REF_MODE_PER_SCAN: ref_nxt = scan_busy | short_wait;
			REF_MODE_ALWAYS:   ref_nxt = 1'b1;
			default:           ref_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_r <= 1'b0;
		end else begin
			ref_r <= ref_nxt;
		end
	end

	assign ref_power_on = ref_r;

	// In single-ended mode the negative input is grounded and both mux outputs
	// show the selected channel. In differential mode the lowest select bit is
	// ignored: any channel of a pair selects the whole pair, even one positive.
	// The routing is registered so that the mux never sees a decode glitch.
	//
	// Channel routing: a differential selection maps to its even/odd pair.
	logic [CNT_W-1:0] pos_r, pos_nxt, neg_r, neg_nxt;
	logic             gnd_r, gnd_nxt;

	always_comb begin
		pos_nxt = chan_sel;
		neg_nxt = chan_sel;
		gnd_nxt = 1'b1;
		if (diff_mode) begin
			pos_nxt = {chan_sel[CNT_W-1:1], 1'b0};
			neg_nxt = {chan_sel[CNT_W-1:1], 1'b1};
			gnd_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_r <= '0;
			neg_r <= '0;
			gnd_r <= 1'b1;
		end else begin
			pos_r <= pos_nxt;
			neg_r <= neg_nxt;
			gnd_r <= gnd_nxt;
		end
	end

	assign mux_pos     = pos_r;
	assign mux_neg     = neg_r;
	assign mux_neg_gnd = gnd_r;

	// The port has no long counters; every timing figure of the link is met by
	// the host's edge spacing, which the synchronisers turn into clock counts.
	// Nothing here depends on the serial clock running between frames.

endmodule : msp_serial_port

// *** tb/msp_monitor.sv ***
module msp_monitor
	import msp_pkg::*;
(
	// Serial pins.
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic xfer_start,
	// Alarm, reference and mux.
	input wire logic alarm_event,
	input wire msp_alarm_cfg_t alarm_cfg,
	input wire logic alarm_o,
	input wire logic alarm_oe,
	input wire logic [1:0] ref_mode,
	input wire logic [WAIT_W-1:0] scan_wait_us,
	input wire logic temp_conv_busy,
	input wire logic scan_busy,
	input wire logic ref_power_on,
	input wire logic diff_mode,
	input wire logic [CNT_W-1:0] chan_sel,
	input wire logic [CNT_W-1:0] mux_pos,
	input wire logic [CNT_W-1:0] mux_neg,
	input wire logic mux_neg_gnd
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// The pin sync adds latency, so deselect and select get a few cycles of slack.
	idle_hiz_a: assert property (cs_n [*5] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	start_seen_a: assert property ($fell(cs_n) |-> ##[2:5] (xfer_start && sdo_oe))
		else $error("no start after select");
	dout_fall_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sclk)
		else $error("sdo moved while clock high");
	// Registered outputs: the edge right after reset still shows reset values.
	alarm_pp_a: assert property ($past(rst_n) && !$past(alarm_cfg.open_drain) |->
		alarm_oe && alarm_o == ($past(alarm_event) ~^ $past(alarm_cfg.active_high)))
		else $error("alarm push-pull level wrong");
	ref_temp_a: assert property ($past(rst_n) && $past(ref_mode) == REF_MODE_PER_TEMP
		|-> ref_power_on == $past(temp_conv_busy)) else $error("ref per temp wrong");
	ref_scan_a: assert property ($past(rst_n) && $past(ref_mode) == REF_MODE_PER_SCAN
		|-> ref_power_on == ($past(scan_busy) || $past(scan_wait_us) < REF_HOLD_WAIT_US))
		else $error("ref per scan wrong");
	ref_on_a: assert property ($past(rst_n) && $past(ref_mode[1]) |-> ref_power_on)
		else $error("ref not held on");
	pair_sel_a: assert property ($past(rst_n) && $past(diff_mode) |-> !mux_neg_gnd &&
		mux_pos == {$past(chan_sel[2:1]), 1'h0} && mux_neg == {$past(chan_sel[2:1]), 1'h1})
		else $error("diff pair wrong");
	cover property (xfer_start);
	cover property (alarm_oe && alarm_cfg.open_drain);
	cover property (ref_power_on && ref_mode == REF_MODE_PER_SCAN);
endmodule : msp_monitor

// *** tb/msp_host_model.sv ***
module msp_host_model (
	// Pins towards the device.
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	// Pins from the device.
	input  wire logic sdo_o,
	input  wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n = 1'h1;
		sclk = 1'h0;
		sdi = 1'h0;
	end
	// One frame in mode 0 or 3; fewer than eight bits makes an aborted frame.
	task automatic xfer(input logic m, input int nb, input logic [7:0] d, output logic [7:0] q);
		q = 8'h00;
		sclk = m;
		cs_n = 1'h0;
		#100;
		for (int i = 7; i > 7 - nb; i--) begin
			sclk = 1'h0;
			sdi = d[i];
			#62.5 sclk = 1'h1;
			q[i] = sdo_oe ? sdo_o : ~sdo_o; // An undriven line reads wrong on purpose.
			#62.5;
		end
		sclk = m;
		#62.5 cs_n = 1'h1;
		sdi = ~sdi; // Data is meaningless between frames, so it keeps moving.
		#62.5;
	endtask : xfer
endmodule : msp_host_model

// *** tb/msp_serial_port_bench.sv ***
module msp_serial_port_bench
	import msp_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic cs_n, sclk, sdi, sdo_o, sdo_oe, rx_valid, xfer_start, alarm_o, alarm_oe;
	logic ref_power_on, mux_neg_gnd;
	logic alarm_event = 1'h0, temp_conv_busy = 1'h0, scan_busy = 1'h0, diff_mode = 1'h0;
	msp_alarm_cfg_t alarm_cfg = '0;
	logic [1:0] ref_mode = 2'h0;
	logic [WAIT_W-1:0] scan_wait_us = 16'h0000;
	logic [CNT_W-1:0] chan_sel = 3'h0, mux_pos, mux_neg;
	logic [SHIFT_W-1:0] tx_word = 8'h00, rx_word, t, d, q, er;
	logic [9:0] pins, e;
	int fails = 0, compares = 0, nrx = 0, erx = 0, nb;
	msp_serial_port u_dut (.*);
	msp_host_model u_host (.*);
	assign pins = {alarm_o, alarm_oe, ref_power_on, mux_pos, mux_neg, mux_neg_gnd};
	always #5 sys_clk = ~sys_clk;
	// Counting pulses catches an aborted frame that still reports a byte.
	always @(posedge sys_clk) if (rx_valid === 1'h1) nrx <= nrx + 1;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// Expected registered pin levels for the control inputs now applied.
	function automatic logic [9:0] pins_exp();
		logic lvl;
		logic on;
		lvl = alarm_event ~^ alarm_cfg.active_high;
		on = ref_mode[1] | (ref_mode[0] ? scan_busy || scan_wait_us < REF_HOLD_WAIT_US : temp_conv_busy);
		return {alarm_cfg.open_drain ? {1'h0, !lvl} : {lvl, 1'h1}, on, diff_mode ?
			{chan_sel[2:1], 1'h0, chan_sel[2:1], 2'h2} : {chan_sel, chan_sel, 1'h1}};
	endfunction : pins_exp
	initial begin
		void'($urandom(32'h04B22251));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'h1;
		// Random controls, with the wait mostly straddling the hold threshold.
		repeat (300) begin
			@(posedge sys_clk);
			{alarm_event, alarm_cfg, temp_conv_busy, scan_busy, diff_mode, ref_mode,
				chan_sel} <= 11'($urandom);
			scan_wait_us <= $urandom % 4 ? 16'h004F + 16'($urandom % 2) : 16'($urandom);
			@(posedge sys_clk);
			#1 e = pins_exp();
			chk(16'(pins[9:8]), 16'(e[9:8]));
			chk(16'(pins[7]), 16'(e[7]));
			chk(16'(pins[6:0]), 16'(e[6:0]));
		end
		// Frames alternate mode 0 and 3; every fourth one is cut after five bits.
		for (int k = 0; k < 24; k++) begin
			{t, d} = 16'($urandom);
			if (k == 0) {t, d} = 16'h00FF;
			nb = k % 4 == 3 ? 5 : 8;
			er = nb == 8 ? d : er;
			erx += nb / 8;
			@(posedge sys_clk);
			tx_word <= t;
			@(posedge sys_clk);
			#2 u_host.xfer(1'(k), nb, d, q);
			chk(16'(q), 16'(t & (8'hFF << (8 - nb))));
			chk(16'(rx_word), 16'(er));
			chk(16'(nrx), 16'(erx));
			chk(16'(sdo_oe), 16'h0000);
		end
		tally_and_finish();
	end
	// The whole run needs about 34 us; about six times that means a hang.
	initial begin
		#200000;
		fails++;
		tally_and_finish();
	end
endmodule : msp_serial_port_bench
bind msp_serial_port msp_monitor u_mon (.*);
